// ---- bsr_pkg.sv ----
// Constants, offsets and encodings of the S-curve reference broadcaster.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
package bsr_pkg;

	// Update period and its cycle count.
	localparam int unsigned CLK_FREQ_MHZ     = 125;
	localparam int unsigned UPDATE_PERIOD_US = 1024;
	localparam int unsigned UPDATE_CYCLES    = UPDATE_PERIOD_US * CLK_FREQ_MHZ;

	// Register offsets.
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_DEMAND   = 8'h04;
	localparam logic [7:0] OFS_ACCEL    = 8'h08;
	localparam logic [7:0] OFS_DECEL    = 8'h0c;
	localparam logic [7:0] OFS_JERK1    = 8'h10;
	localparam logic [7:0] OFS_JERK4    = 8'h1c;
	localparam logic [7:0] OFS_OFFSET   = 8'h20;
	localparam logic [7:0] OFS_MAXSPD   = 8'h24;
	localparam logic [7:0] OFS_STATUS   = 8'h28;
	localparam logic [7:0] OFS_SPEED    = 8'h2c;
	localparam logic [7:0] OFS_POSITION = 8'h30;
	localparam logic [7:0] OFS_ACC_OUT  = 8'h34;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;

	// Control and status register fields.
	localparam int unsigned CTRL_RUN    = 8;
	localparam int unsigned CTRL_HOLD   = 9;
	localparam int unsigned CTRL_RESET  = 10;
	localparam int unsigned CTRL_EQUAL  = 11;
	localparam int unsigned CTRL_SMOOTH = 12;
	localparam int unsigned STAT_RAMP   = 4;

	// Limits and values after reset.
	localparam logic [6:0]  CH_MAX      = 7'h40;
	localparam logic [15:0] DEMAND_MAX  = 16'h2710;
	localparam logic [15:0] RATE_MAX    = 16'h2710;
	localparam logic [15:0] RATE_RST    = 16'h03e8;
	localparam logic [15:0] MAXSPD_MIN  = 16'h03e8;
	localparam logic [15:0] MAXSPD_MAX  = 16'hea60;
	localparam logic [15:0] MAXSPD_RST  = 16'h3a98;
	localparam logic [22:0] OFFSET_MAX  = 23'h36ee80;

	// Fixed point scaling of speed and position.
	localparam logic [39:0] POS_SCALE = 40'h0000001400;
	localparam logic [39:0] POS_WRAP  = 40'h044aa20000;
	localparam logic signed [35:0] POS_GAIN = 36'sh000000003;
	localparam logic signed [32:0] SPD_DIV  = 33'sh00000ea60;

	// Operating status codes.
	localparam logic [2:0] ST_READY    = 3'h0;
	localparam logic [2:0] ST_RESET    = 3'h1;
	localparam logic [2:0] ST_CONFLICT = 3'h2;
	localparam logic [2:0] ST_PENDING  = 3'h3;
	localparam logic [2:0] ST_NO_BUS   = 3'h4;
	localparam logic [2:0] ST_DISABLED = 3'h5;

	// Interrupt status bits.
	localparam int unsigned IRQ_W         = 3;
	localparam int unsigned IRQ_TX_DONE   = 0;
	localparam int unsigned IRQ_RAMP_DONE = 1;
	localparam int unsigned IRQ_STAT_CHG  = 2;

	typedef enum logic [0:0] {BSR_IDLE, BSR_SEND} bsr_tx_state_t;

endpackage : bsr_pkg

// ---- bsr_tick.sv ----
// Divider that gives a one-cycle update enable every CYCLES clocks.
// Assumes the single system clock and its asynchronous reset.
`timescale 1ns/10ps
module bsr_tick #(
	parameter int unsigned CYCLES = 128000
) (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Update enable.
	output logic      tick
);
	import bsr_pkg::*;

	logic [31:0] count;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 32'h0;
			tick  <= 1'b0;
		end else if (count == 32'(CYCLES - 1)) begin
			count <= 32'h0;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick  <= 1'b0;
		end
	end

endmodule : bsr_tick

// ---- bsr_bcast.sv ----
// Sends one speed, position and acceleration triple as three words.
// Assumes the bus link takes a word when tx_valid and tx_ready are high.
`timescale 1ns/10ps
module bsr_bcast (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Triple to send.
	input  wire logic        start,
	input  wire logic [6:0]  channel,
	input  wire logic [31:0] word_speed,
	input  wire logic [31:0] word_pos,
	input  wire logic [31:0] word_acc,
	// Link side.
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [6:0]       tx_channel,
	output logic [31:0]      tx_data,
	output logic [1:0]       tx_kind,
	output logic             tx_last,
	// Completion.
	output logic             done
);
	import bsr_pkg::*;

	bsr_tx_state_t state;
	logic [31:0]   word1;
	logic [31:0]   word2;

	assign tx_valid = (state == BSR_SEND);
	assign tx_last  = (tx_kind == 2'h2);

	// A start while a triple is still going out is dropped.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state      <= BSR_IDLE;
			tx_channel <= 7'h0;
			tx_data    <= 32'h0;
			tx_kind    <= 2'h0;
			word1      <= 32'h0;
			word2      <= 32'h0;
			done       <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				BSR_IDLE: begin
					if (start) begin
						state      <= BSR_SEND;
						tx_channel <= channel;
						tx_data    <= word_speed;
						word1      <= word_pos;
						word2      <= word_acc;
						tx_kind    <= 2'h0;
					end
				end
				BSR_SEND: begin
					if (tx_ready) begin
						tx_data <= word1;
						word1   <= word2;
						tx_kind <= tx_kind + 2'h1;
						if (tx_last) begin
							state <= BSR_IDLE;
							done  <= 1'b1;
						end
					end
				end
				default: state <= BSR_IDLE;
			endcase
		end
	end

endmodule : bsr_bcast

// ---- bsr_master.sv ----
// S-curve reference generator that broadcasts speed, position and
// acceleration on a bus channel. Assumes one 125 MHz clock, AHB-Lite
// register access and a bus link that reports its own state on pins.
`timescale 1ns/10ps
// Operation
// - Each update with status 0 the speed, position and acceleration triple is broadcast.
// - Channel setting 0 to 64 picks the broadcast channel, default 0.
// - Channel zero keeps the block disabled with status 5.
// - Another broadcaster on the same channel gives status 2.
// - Status 3 while bus state unknown, status 4 when bus or power absent.
// - Status 0 when operating, status 1 when the run input is false.
// - Demand input is minus to plus 100 percent, default zero.
// - Rising speed is limited by acceleration, 0 to 100, default 10.
// - Falling speed is limited by deceleration with the same range.
// - Four jerk settings, 0 to 100, shape segments one to four.
// - Smooth retarget blends a new setpoint, otherwise jumps to new curve.
// - Hold freezes the profile output at its last value.
// - Equal jerk uses the first jerk setting for all four segments.
// - Reset flag forces the output equal to the demand unless hold is set.
// - An offset of 0 to 360 degrees is added to the position.
// - Maximum speed 100 to 6000 rpm, default 1500, scales the output.
// - Ramping flag is high while the output moves toward its target.
module bsr_master #(
	parameter int unsigned UPDATE_CYCLES = bsr_pkg::UPDATE_CYCLES
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Bus link state.
	input  wire logic        bus_present,
	input  wire logic        bus_powered,
	input  wire logic        bus_state_known,
	input  wire logic        channel_conflict,
	// Broadcast words.
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [6:0]       tx_channel,
	output logic [31:0]      tx_data,
	output logic [1:0]       tx_kind,
	output logic             tx_last,
	// Interrupt.
	output logic             irq
);
	import bsr_pkg::*;

	// Settings.
	logic [6:0]         channel;
	logic               run;
	logic               hold_en;
	logic               reset_en;
	logic               equal_jerk_select;
	logic               smooth_retarget;
	logic signed [15:0] demand;
	logic [15:0]        accel_set;
	logic [15:0]        decel_set;
	logic [15:0]        jerk_set [4];
	logic [21:0]        offset;
	logic [15:0]        max_speed;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_mask;

	// Bus slave state.
	logic               bus_acc;
	logic               wr_pend;
	logic [7:0]         wr_addr;
	logic [31:0]        rd_val;
	logic               rd_clr;

	// Profile state.
	logic               tick;
	logic [1:0]         tick_pipe;
	logic signed [35:0] v_q;
	logic signed [27:0] a_q;
	logic signed [15:0] last_tgt;
	logic [39:0]        pos_acc;
	logic               ramping;
	logic [2:0]         status;
	logic [2:0]         next_status;
	logic signed [31:0] spd_out;
	logic [31:0]        pos_out;
	logic signed [31:0] acc_out;
	logic               tx_done;
	logic               ramp_prev;

	// Step of the profile.
	logic signed [35:0] tgt_q;
	logic signed [35:0] err_q;
	logic signed [35:0] gap_q;
	logic               neg;
	logic signed [27:0] ma;
	logic signed [27:0] nma;
	logic [15:0]        alim;
	logic [15:0]        jup;
	logic [15:0]        jdn;
	logic [31:0]        brake_lhs;
	logic [31:0]        brake_rhs;
	logic               snap;
	logic signed [27:0] next_a;
	logic signed [35:0] next_v;
	logic signed [15:0] v_int;
	logic signed [32:0] prod;
	logic signed [35:0] dpos;
	logic signed [40:0] psum;
	logic [39:0]        next_pos;
	logic [39:0]        pos_div;
	logic [22:0]        pos_sum;

	function automatic logic [15:0] clamp_rate(input logic [15:0] x);
		clamp_rate = (x > RATE_MAX) ? RATE_MAX : x;
	endfunction : clamp_rate

	function automatic logic signed [15:0] clamp_dem(
		input logic signed [15:0] x);
		if (x > $signed(DEMAND_MAX))
			clamp_dem = $signed(DEMAND_MAX);
		else if (x < -$signed(DEMAND_MAX))
			clamp_dem = -$signed(DEMAND_MAX);
		else
			clamp_dem = x;
	endfunction : clamp_dem

	bsr_tick #(
		.CYCLES (UPDATE_CYCLES)
	) u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (tick)
	);

	// Bus slave: zero wait states, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign bus_acc   = hsel & hready & htrans[1];
	assign rd_clr    = bus_acc & ~hwrite & (haddr[7:0] == OFS_IRQ_STAT);

	always_comb begin
		rd_val = 32'h0;
		if (haddr[7:0] == OFS_CTRL)
			rd_val = 32'({smooth_retarget, equal_jerk_select, reset_en,
				hold_en, run, 1'b0, channel});
		else if (haddr[7:0] == OFS_DEMAND)
			rd_val = 32'(demand);
		else if (haddr[7:0] == OFS_ACCEL)
			rd_val = 32'(accel_set);
		else if (haddr[7:0] == OFS_DECEL)
			rd_val = 32'(decel_set);
		else if (haddr[7:0] >= OFS_JERK1 && haddr[7:0] <= OFS_JERK4)
			rd_val = 32'(jerk_set[haddr[3:2]]);
		else if (haddr[7:0] == OFS_OFFSET)
			rd_val = 32'(offset);
		else if (haddr[7:0] == OFS_MAXSPD)
			rd_val = 32'(max_speed);
		else if (haddr[7:0] == OFS_STATUS)
			rd_val = 32'({ramping, 1'b0, status});
		else if (haddr[7:0] == OFS_SPEED)
			rd_val = spd_out;
		else if (haddr[7:0] == OFS_POSITION)
			rd_val = pos_out;
		else if (haddr[7:0] == OFS_ACC_OUT)
			rd_val = acc_out;
		else if (haddr[7:0] == OFS_IRQ_STAT)
			rd_val = 32'(irq_stat);
		else if (haddr[7:0] == OFS_IRQ_MASK)
			rd_val = 32'(irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
			hrdata  <= 32'h0;
		end else begin
			wr_pend <= bus_acc & hwrite;
			if (bus_acc)
				wr_addr <= haddr[7:0];
			if (bus_acc & ~hwrite)
				hrdata <= rd_val;
		end
	end

	// Settings written in the data phase, each clamped to its range.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel           <= 7'h0;
			run               <= 1'b1;
			hold_en           <= 1'b0;
			reset_en          <= 1'b0;
			equal_jerk_select <= 1'b0;
			smooth_retarget   <= 1'b0;
			demand            <= 16'sh0;
			accel_set         <= RATE_RST;
			decel_set         <= RATE_RST;
			for (int i = 0; i < 4; i++)
				jerk_set[i] <= RATE_RST;
			offset            <= 22'h0;
			max_speed         <= MAXSPD_RST;
			irq_mask          <= '0;
		end else if (wr_pend) begin
			if (wr_addr == OFS_CTRL) begin
				channel <= (hwdata[6:0] > CH_MAX) ? CH_MAX : hwdata[6:0];
				run               <= hwdata[CTRL_RUN];
				hold_en           <= hwdata[CTRL_HOLD];
				reset_en          <= hwdata[CTRL_RESET];
				equal_jerk_select <= hwdata[CTRL_EQUAL];
				smooth_retarget   <= hwdata[CTRL_SMOOTH];
			end else if (wr_addr == OFS_DEMAND) begin
				demand <= clamp_dem(hwdata[15:0]);
			end else if (wr_addr == OFS_ACCEL) begin
				accel_set <= clamp_rate(hwdata[15:0]);
			end else if (wr_addr == OFS_DECEL) begin
				decel_set <= clamp_rate(hwdata[15:0]);
			end else if (wr_addr >= OFS_JERK1 && wr_addr <= OFS_JERK4) begin
				jerk_set[wr_addr[3:2]] <= clamp_rate(hwdata[15:0]);
			end else if (wr_addr == OFS_OFFSET) begin
				offset <= (hwdata[22:0] > OFFSET_MAX) ? OFFSET_MAX[21:0] :
					hwdata[21:0];
			end else if (wr_addr == OFS_MAXSPD) begin
				if (hwdata[15:0] < MAXSPD_MIN)
					max_speed <= MAXSPD_MIN;
				else if (hwdata[15:0] > MAXSPD_MAX)
					max_speed <= MAXSPD_MAX;
				else
					max_speed <= hwdata[15:0];
			end else if (wr_addr == OFS_IRQ_MASK) begin
				irq_mask <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// One jerk-limited step toward the demand.
	always_comb begin
		tgt_q = {demand, 20'h0};
		err_q = tgt_q - v_q;
		neg   = err_q[35];
		gap_q = neg ? -err_q : err_q;
		ma    = neg ? -a_q : a_q;
		alim  = neg ? decel_set : accel_set;
		// Rising speed uses segments 1 and 2, falling uses 3 and 4.
		jup   = neg ? jerk_set[2] : jerk_set[0];
		jdn   = neg ? jerk_set[3] : jerk_set[1];
		if (equal_jerk_select) begin
			jup = jerk_set[0];
			jdn = jerk_set[0];
		end
		brake_lhs = 32'(jdn) * 32'(gap_q[35:20]) * 32'h2;
		brake_rhs = 32'(ma[25:10]) * 32'(ma[25:10]);
		nma = ma;
		if (ma > 28'sh0 && brake_lhs <= brake_rhs) begin
			nma = ma - $signed({12'h0, jdn});
			if (nma < 28'sh0)
				nma = 28'sh0;
		end else if (ma < $signed({2'b00, alim, 10'h0})) begin
			nma = ma + $signed({12'h0, jup});
			if (nma > $signed({2'b00, alim, 10'h0}))
				nma = $signed({2'b00, alim, 10'h0});
		end else if (ma > $signed({2'b00, alim, 10'h0})) begin
			nma = ma - $signed({12'h0, jdn});
			if (nma < $signed({2'b00, alim, 10'h0}))
				nma = $signed({2'b00, alim, 10'h0});
		end
		snap   = (gap_q <= 36'(nma));
		next_a = snap ? 28'sh0 : (neg ? -nma : nma);
		next_v = snap ? tgt_q : v_q + 36'(next_a);
	end

	// Speed, position and acceleration state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			v_q      <= 36'sh0;
			a_q      <= 28'sh0;
			last_tgt <= 16'sh0;
		end else if (tick && !hold_en) begin
			last_tgt <= demand;
			if (reset_en) begin
				v_q <= tgt_q;
				a_q <= 28'sh0;
			end else if (demand != last_tgt && !smooth_retarget) begin
				a_q <= 28'sh0;
			end else begin
				v_q <= next_v;
				a_q <= next_a;
			end
		end
	end

	assign v_int = v_q[35:20];
	assign prod  = v_int * $signed({1'b0, max_speed});
	assign dpos  = 36'(prod) * POS_GAIN;

	always_comb begin
		psum = $signed({1'b0, pos_acc}) + 41'(dpos);
		if (psum < 41'sh0)
			next_pos = 40'(psum) + POS_WRAP;
		else if (psum >= $signed({1'b0, POS_WRAP}))
			next_pos = 40'(psum) - POS_WRAP;
		else
			next_pos = 40'(psum);
		pos_div = pos_acc / POS_SCALE;
		pos_sum = pos_div[22:0] + {1'b0, offset};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pos_acc <= 40'h0;
		else if (tick && !hold_en)
			pos_acc <= next_pos;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ramping <= 1'b0;
		else
			ramping <= (v_q != tgt_q) || (a_q != 28'sh0);
	end

	// Published triple, latched one cycle after each update.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_pipe <= 2'h0;
			spd_out   <= 32'sh0;
			pos_out   <= 32'h0;
			acc_out   <= 32'sh0;
		end else begin
			tick_pipe <= {tick_pipe[0], tick};
			if (tick_pipe[0]) begin
				spd_out <= 32'(prod / SPD_DIV);
				pos_out <= (pos_sum >= OFFSET_MAX) ?
					32'(pos_sum - OFFSET_MAX) : 32'(pos_sum);
				acc_out <= 32'($signed(a_q[27:10]));
			end
		end
	end

	// Status code, first matching cause wins.
	always_comb begin
		if (!bus_present || !bus_powered)
			next_status = ST_NO_BUS;
		else if (!bus_state_known)
			next_status = ST_PENDING;
		else if (channel == 7'h0)
			next_status = ST_DISABLED;
		else if (!run)
			next_status = ST_RESET;
		else if (channel_conflict)
			next_status = ST_CONFLICT;
		else
			next_status = ST_READY;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status <= ST_NO_BUS;
		else
			status <= next_status;
	end

	// Broadcast only while operating correctly.
	bsr_bcast u_bcast (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.start      (tick_pipe[1] && next_status == ST_READY),
		.channel    (channel),
		.word_speed (spd_out),
		.word_pos   (pos_out),
		.word_acc   (acc_out),
		.tx_valid   (tx_valid),
		.tx_ready   (tx_ready),
		.tx_channel (tx_channel),
		.tx_data    (tx_data),
		.tx_kind    (tx_kind),
		.tx_last    (tx_last),
		.done       (tx_done)
	);

	// Sticky events, cleared by a read; a new event wins over the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat  <= '0;
			ramp_prev <= 1'b0;
		end else begin
			ramp_prev <= ramping;
			irq_stat  <= (rd_clr ? '0 : irq_stat) | {
				status != next_status,
				ramp_prev & ~ramping,
				tx_done};
		end
	end

	assign irq = |(irq_stat & irq_mask);

endmodule : bsr_master

// ---- bsr_master_props.sv ----
// Checker of the broadcast port of the reference broadcaster.
// Assumes it is bound into bsr_master and sees only its ports.
`timescale 1ns/10ps
module bsr_master_props #(
	parameter int unsigned UPDATE_CYCLES = 128000
) (
	// Clock and reset.
	input wire logic        hclk,
	input wire logic        hresetn,
	// Link state and broadcast words.
	input wire logic        bus_present,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [6:0]  tx_channel,
	input wire logic [31:0] tx_data,
	input wire logic [1:0]  tx_kind,
	input wire logic        tx_last
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_kind_first;
		$rose(tx_valid) |-> tx_kind == 2'h0 && !tx_last;
	endproperty
	a_kind_first: assert property (p_kind_first)
		else $error("triple does not open with speed");
	property p_word_held;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
			&& $stable(tx_kind);
	endproperty
	a_word_held: assert property (p_word_held)
		else $error("offered word changed before taken");
	property p_pos_next;
		tx_valid && tx_ready && tx_kind == 2'h0 |=> tx_valid
			&& tx_kind == 2'h1;
	endproperty
	a_pos_next: assert property (p_pos_next)
		else $error("position does not follow speed");
	property p_acc_next;
		tx_valid && tx_ready && tx_kind == 2'h1 |=> tx_valid
			&& tx_kind == 2'h2;
	endproperty
	a_acc_next: assert property (p_acc_next)
		else $error("acceleration does not follow position");
	property p_gap;
		tx_valid && tx_ready && tx_last |=> !tx_valid;
	endproperty
	a_gap: assert property (p_gap)
		else $error("no idle cycle after a triple");
	property p_last;
		tx_valid |-> tx_last == (tx_kind == 2'h2);
	endproperty
	a_last: assert property (p_last)
		else $error("last flag not on the third word");
	property p_chan;
		tx_valid |-> tx_channel != 7'h00 && tx_channel <= 7'h40;
	endproperty
	a_chan: assert property (p_chan)
		else $error("broadcast on a channel out of range");
	property p_chan_steady;
		tx_valid && $past(tx_valid) |-> $stable(tx_channel);
	endproperty
	a_chan_steady: assert property (p_chan_steady)
		else $error("channel changed within a triple");
	property p_no_bus;
		(!bus_present) [*8] |-> !$rose(tx_valid);
	endproperty
	a_no_bus: assert property (p_no_bus)
		else $error("triple started without a bus");
endmodule : bsr_master_props

bind bsr_master bsr_master_props #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_props (
	.hclk(hclk), .hresetn(hresetn), .bus_present(bus_present),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_channel(tx_channel),
	.tx_data(tx_data), .tx_kind(tx_kind), .tx_last(tx_last));

// ---- bsr_link_model.sv ----
// Listening drive on the broadcast channel; records the last triple.
// Assumes the bench paces it through slow and stall.
`timescale 1ns/10ps
module bsr_link_model (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Pace set by the bench.
	input  wire logic        slow,
	input  wire logic        stall,
	// Broadcast words.
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic [6:0]  tx_channel,
	input  wire logic [31:0] tx_data,
	input  wire logic [1:0]  tx_kind,
	input  wire logic        tx_last
);
	logic [31:0] got_data [3];
	logic [1:0]  got_kind [3];
	logic [6:0]  got_chan;
	int          idx;
	int          n_triples;
	// Slow pace accepts on every other cycle only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !stall && (!slow || !tx_ready);
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx <= 0;
			n_triples <= 0;
		end else if (tx_valid && tx_ready && idx < 3) begin
			got_data[idx] <= tx_data;
			got_kind[idx] <= tx_kind;
			got_chan <= tx_channel;
			idx <= tx_last ? 0 : idx + 1;
			if (tx_last) begin
				n_triples <= n_triples + 1;
			end
		end
	end
endmodule : bsr_link_model

// ---- bsr_master_tb_top.sv ----
// Self-checking bench of the reference broadcaster.
// Assumes the checker and the listening drive model are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module bsr_master_tb_top;
	import bsr_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, slow, stall;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, tx_kind;
	logic [3:0]  pins;
	logic [6:0]  tx_channel;
	logic [31:0] tx_data;
	logic        tx_valid, tx_ready, tx_last, irq, hresp;
	wire         hready;
	int          err_total = 0;
	int          check_count = 0;
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	bsr_master #(.UPDATE_CYCLES(64)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .bus_present(pins[3]),
		.bus_powered(pins[2]), .bus_state_known(pins[1]),
		.channel_conflict(pins[0]), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_channel(tx_channel), .tx_data(tx_data),
		.tx_kind(tx_kind), .tx_last(tx_last), .irq(irq));
	bsr_link_model link (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.stall(stall), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_channel(tx_channel), .tx_data(tx_data), .tx_kind(tx_kind),
		.tx_last(tx_last));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		int lim;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		lim = n;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		for (n = 0; n < 50; n++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		rd = hrdata;
		if (n == 50 || lim == 50) begin
			err_total++;
			complete_run();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic wait_triples(input int k);
		int t0, n;
		t0 = link.n_triples;
		for (n = 0; n < 600 * k; n++) begin
			@(posedge hclk);
			if (link.n_triples >= t0 + k) break;
		end
		if (n == 600 * k) begin
			err_total++;
			complete_run();
		end
	endtask : wait_triples
	task automatic t_defaults();
		logic [31:0] d;
		logic [7:0]  oa [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
			8'h1c, 8'h20, 8'h24, 8'h40};
		logic [31:0] ex [9] = '{32'h100, 0, 32'h3e8, 32'h3e8, 32'h3e8,
			32'h3e8, 0, 32'h3a98, 0};
		bus(1'b0, OFS_STATUS, 0, d);
		`CHK("status", 3'h4, d[2:0])
		foreach (oa[i]) begin
			bus(1'b0, oa[i], 0, d);
			`CHK("reset value", ex[i], d)
		end
		$display("t_defaults done");
	endtask : t_defaults
	task automatic t_clamp();
		logic [31:0] d;
		logic [7:0]  oa [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20,
			8'h24};
		logic [31:0] wv [7] = '{32'h17f, 32'h4e20, 32'h4e20, 32'h4e20,
			32'h4e20, 32'hffffff, 32'h64};
		logic [31:0] ex [7] = '{32'h140, 32'h2710, 32'h2710, 32'h2710,
			32'h2710, 32'h36ee80, 32'h3e8};
		foreach (oa[i]) begin
			wr(oa[i], wv[i]);
			bus(1'b0, oa[i], 0, d);
			`CHK("clamped", ex[i], d)
		end
		wr(OFS_DEMAND, 0);
		$display("t_clamp done");
	endtask : t_clamp
	task automatic t_status();
		logic [31:0] d;
		logic [3:0]  pv [7] = '{4'h7, 4'ha, 4'hc, 4'he, 4'he, 4'hf, 4'he};
		logic [31:0] cv [7] = '{32'h105, 32'h105, 32'h105, 32'h100,
			32'h005, 32'h105, 32'h105};
		logic [2:0]  ex [7] = '{3'h4, 3'h4, 3'h3, 3'h5, 3'h1, 3'h2, 3'h0};
		foreach (pv[i]) begin
			pins <= pv[i];
			wr(OFS_CTRL, cv[i]);
			repeat (2) @(posedge hclk);
			bus(1'b0, OFS_STATUS, 0, d);
			`CHK("status code", ex[i], d[2:0])
		end
		$display("t_status done");
	endtask : t_status
	task automatic t_bcast();
		logic [31:0] d;
		logic [5:0]  k;
		slow <= 1'b1;
		wait_triples(2);
		k = {link.got_kind[2], link.got_kind[1], link.got_kind[0]};
		`CHK("kinds", 6'h24, k)
		`CHK("channel", 7'h05, link.got_chan)
		`CHK("masked irq", 1'b0, irq)
		bus(1'b0, OFS_STATUS, 0, d);
		`CHK("settled", 1'b0, d[4])
		wr(OFS_IRQ_MASK, 32'h1);
		stall <= 1'b1;
		repeat (2) @(posedge hclk);
		bus(1'b0, OFS_IRQ_STAT, 0, d);
		`CHK("sent flag", 1'b1, d[0])
		bus(1'b0, OFS_IRQ_STAT, 0, d);
		`CHK("sent flag cleared", 1'b0, d[0])
		`CHK("irq cleared", 1'b0, irq)
		stall <= 1'b0;
		wait_triples(1);
		@(posedge hclk);
		`CHK("irq raised", 1'b1, irq)
		wr(OFS_IRQ_MASK, 0);
		$display("t_bcast done");
	endtask : t_bcast
	task automatic t_profile();
		logic [31:0] d;
		wr(OFS_MAXSPD, 32'h3a98);
		wr(OFS_OFFSET, 32'd900000);
		wr(OFS_CTRL, 32'h505);
		wait_triples(2);
		bus(1'b0, OFS_POSITION, 0, d);
		`CHK("offset position", 32'd900000, d)
		wr(OFS_DEMAND, 32'd4000);
		wait_triples(2);
		bus(1'b0, OFS_SPEED, 0, d);
		`CHK("forced speed", 32'd1000, d)
		`CHK("sent speed", 32'd1000, link.got_data[0])
		wr(OFS_DECEL, 32'd10000);
		wr(OFS_CTRL, 32'h305);
		wr(OFS_DEMAND, 0);
		wait_triples(3);
		bus(1'b0, OFS_SPEED, 0, d);
		`CHK("held speed", 32'd1000, d)
		wr(OFS_CTRL, 32'h105);
		wait_triples(3);
		bus(1'b0, OFS_STATUS, 0, d);
		`CHK("ramping", 1'b1, d[4])
		bus(1'b0, OFS_SPEED, 0, d);
		`CHK("falling", 1'b1, d < 32'd1000)
		wr(OFS_JERK1, 0);
		wr(OFS_DEMAND, 32'd4000);
		wr(OFS_CTRL, 32'h505);
		wait_triples(2);
		wr(OFS_CTRL, 32'h905);
		wr(OFS_DEMAND, 0);
		wait_triples(3);
		bus(1'b0, OFS_SPEED, 0, d);
		`CHK("equal jerk speed", 32'd1000, d)
		$display("t_profile done");
	endtask : t_profile
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 0;
		hwrite = 1'b0;
		hwdata = 0;
		pins = 4'h0;
		slow = 1'b0;
		stall = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_defaults();
		t_clamp();
		t_status();
		t_bcast();
		t_profile();
		complete_run();
	end
endmodule : bsr_master_tb_top
